// [dpp_pkg.sv]
// Purpose: shared constants, types and helpers for the dual parallel port block
// Assumes: 8-bit host I/O bus, one reset, sys_clk at 100 MHz
// Notes: unit 0 may run handshake modes, unit 1 is mode 0 only
`default_nettype none

package dpp_pkg;

   localparam logic [7:0] ADDR_U0_A = 8'he4;
   localparam logic [7:0] ADDR_U0_B = 8'he5;
   localparam logic [7:0] ADDR_U0_C = 8'he6;
   localparam logic [7:0] ADDR_U0_CTL = 8'he7;
   localparam logic [7:0] ADDR_U1_A = 8'he8;
   localparam logic [7:0] ADDR_U1_B = 8'he9;
   localparam logic [7:0] ADDR_U1_C = 8'hea;
   localparam logic [7:0] ADDR_U1_CTL = 8'heb;

   localparam logic [1:0] SEL_A = 2'h0;
   localparam logic [1:0] SEL_B = 2'h1;
   localparam logic [1:0] SEL_C = 2'h2;
   localparam logic [1:0] SEL_CTL = 2'h3;

   // control word fields
   localparam int CW_FLAG = 7;
   localparam int CW_GA_HI = 6;
   localparam int CW_GA_LO = 5;
   localparam int CW_A_IN = 4;
   localparam int CW_CU_IN = 3;
   localparam int CW_GB_M1 = 2;
   localparam int CW_B_IN = 1;
   localparam int CW_CL_IN = 0;
   localparam int BSR_SEL_HI = 3;
   localparam int BSR_SEL_LO = 1;
   localparam int BSR_VAL = 0;
   localparam logic [7:0] CW_RESET = 8'h9b;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] RD_NONE = 8'h00;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // port C handshake bit positions
   localparam int PC_INTR_B = 0;
   localparam int PC_IBF_B = 1;
   localparam int PC_STB_B = 2;
   localparam int PC_INTR_A = 3;
   localparam int PC_STB_A = 4;
   localparam int PC_IBF_A = 5;
   localparam int PC_ACK_A = 6;
   localparam int PC_OBF_A = 7;

   typedef enum logic [1:0] {DPP_MODE0, DPP_MODE1, DPP_MODE2} dpp_mode_e;
   typedef enum logic [1:0] {DPP_BUF_OUT, DPP_BUF_IN, DPP_BUF_PROG} dpp_bufdir_e;

   typedef struct packed {
      logic [7:0] c;
      logic [7:0] b;
      logic [7:0] a;
   } dpp_lines_s;

   typedef struct packed {
      dpp_mode_e ga_mode;
      logic a_in;
      logic cu_in;
      logic gb_m1;
      logic b_in;
      logic cl_in;
   } dpp_cfg_s;

   function automatic dpp_cfg_s dpp_decode_cw(input logic [7:0] cw, input logic hs_ok);
      dpp_cfg_s c;
      c.ga_mode = DPP_MODE0;
      if (hs_ok && cw[CW_GA_HI]) begin
         c.ga_mode = DPP_MODE2;
      end else if (hs_ok && cw[CW_GA_LO]) begin
         c.ga_mode = DPP_MODE1;
      end
      c.a_in = cw[CW_A_IN];
      c.cu_in = cw[CW_CU_IN];
      c.gb_m1 = hs_ok & cw[CW_GB_M1];
      c.b_in = cw[CW_B_IN];
      c.cl_in = cw[CW_CL_IN];
      return c;
   endfunction : dpp_decode_cw

   function automatic logic dpp_hit(input logic [7:0] addr);
      return (addr >= ADDR_U0_A) && (addr <= ADDR_U1_CTL);
   endfunction : dpp_hit

   function automatic logic dpp_unit(input logic [7:0] addr);
      return addr >= ADDR_U1_A;
   endfunction : dpp_unit

endpackage : dpp_pkg

`default_nettype wire

// [dpp_sync.sv]
// Purpose: two-stage synchroniser for line and strap inputs
// Assumes: inputs are asynchronous to sys_clk
// Notes: only the second stage is visible outside
`default_nettype none

module dpp_sync #(
   parameter int W = 8
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [W-1:0] d, // raw pin levels
   output var logic [W-1:0] q // synchronised levels
);
   import dpp_pkg::*;

   logic [W-1:0] meta;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule : dpp_sync

`default_nettype wire

// [dpp_strap.sv]
// Purpose: catches the port A buffer direction strap once after reset
// Assumes: strap input already synchronised, static while running
// Notes: 00 or absent jumper = output, 01 = input, 1x = programmable
`default_nettype none

module dpp_strap (
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [1:0] strap, // synchronised strap level
   output dpp_pkg::dpp_bufdir_e dir // captured buffer direction
);
   import dpp_pkg::*;

   logic done;
   logic [1:0] settle;

   // the strap synchroniser is cleared by reset too, so wait until it has refilled
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         settle <= 2'h0;
      end else if (settle != STRAP_SETTLE) begin
         settle <= settle + 2'h1;
      end
   end

   // caught once; until then the default transmit direction stands
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
         dir <= DPP_BUF_OUT;
      end else if (!done && (settle == STRAP_SETTLE)) begin
         done <= 1'b1;
         if (strap[1]) begin
            dir <= DPP_BUF_PROG;
         end else if (strap[0]) begin
            dir <= DPP_BUF_IN;
         end else begin
            dir <= DPP_BUF_OUT;
         end
      end
   end

endmodule : dpp_strap

`default_nettype wire

// [dpp_top.sv]
// Purpose: two programmable parallel interface units, 48 lines in six ports
// Assumes: host I/O strobes are one-cycle pulses synchronous to sys_clk
// Notes: unit 0 adds strobed and bidirectional handshakes, unit 1 is plain
`default_nettype none

module dpp_top (
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst, // async reset, active high
   input wire logic [7:0] io_addr, // host I/O port address
   input wire logic io_wr, // write strobe, one cycle
   input wire logic io_rd, // read strobe, one cycle
   input wire logic [7:0] io_wdata, // write data
   output var logic [7:0] io_rdata, // read data, valid with io_rd_ack
   output var logic io_rd_ack, // read answer pulse
   input wire dpp_pkg::dpp_lines_s u0_line_in, // first unit line levels
   output dpp_pkg::dpp_lines_s u0_line_out, // first unit line drive values
   output dpp_pkg::dpp_lines_s u0_line_oe, // first unit drive enables
   input wire dpp_pkg::dpp_lines_s u1_line_in, // second unit line levels
   output dpp_pkg::dpp_lines_s u1_line_out, // second unit line drive values
   output dpp_pkg::dpp_lines_s u1_line_oe, // second unit drive enables
   input wire logic [1:0] buf_strap, // port A buffer direction strap
   output var logic porta_buf_transmit // port A transceiver toward lines
);
   import dpp_pkg::*;

   logic [47:0] sync_q;
   logic [1:0] strap_q;
   dpp_bufdir_e buf_dir;
   dpp_lines_s pins [2];
   dpp_lines_s out_q [2];
   dpp_lines_s oe_q [2];
   logic [7:0] rd_val [2];
   logic [7:0] a_oe_prog;
   logic hit;
   logic unit;
   logic [1:0] sel;

   dpp_sync #(
      .W(48)
   ) u_line_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({u1_line_in, u0_line_in}),
      .q(sync_q)
   );

   dpp_sync #(
      .W(2)
   ) u_strap_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d(buf_strap),
      .q(strap_q)
   );

   dpp_strap u_strap (
      .sys_clk(sys_clk),
      .rst(rst),
      .strap(strap_q),
      .dir(buf_dir)
   );

   assign pins[0] = sync_q[23:0];
   assign pins[1] = sync_q[47:24];

   // address decode shared by both units
   assign hit = dpp_hit(io_addr);
   assign unit = dpp_unit(io_addr);
   assign sel = io_addr[1:0];

   for (genvar u = 0; u < 2; u++) begin : g_unit
      // only the first unit is wired for handshake modes
      localparam logic HS_OK = (u == 0);

      dpp_cfg_s cfg;
      logic [7:0] lat_a;
      logic [7:0] lat_b;
      logic [7:0] lat_c;
      logic [7:0] hold_a;
      logic [7:0] hold_b;
      logic [7:0] pc_prev;
      logic ibf_a;
      logic obf_a_n;
      logic intr_a;
      logic inte_a_in;
      logic inte_a_out;
      logic ibf_b;
      logic obf_b_n;
      logic intr_b;
      logic inte_b;
      logic mine;
      logic wr_a;
      logic wr_b;
      logic wr_c;
      logic rd_a;
      logic rd_b;
      logic mode_set;
      logic bsr;
      logic [2:0] bsr_bit;
      logic a_m2;
      logic a_hs;
      logic a_hs_in;
      logic a_hs_out;
      logic b_hs_in;
      logic b_hs_out;
      logic stb_a_fall;
      logic stb_a_rise;
      logic ack_a_fall;
      logic ack_a_rise;
      logic stb_b_fall;
      logic stb_b_rise;
      dpp_lines_s next_out;
      dpp_lines_s next_oe;

      assign mine = hit && (unit == 1'(u));
      assign wr_a = io_wr && mine && (sel == SEL_A);
      assign wr_b = io_wr && mine && (sel == SEL_B);
      assign wr_c = io_wr && mine && (sel == SEL_C);
      assign rd_a = io_rd && mine && (sel == SEL_A);
      assign rd_b = io_rd && mine && (sel == SEL_B);
      // bit 7 splits mode definition from single-bit set/reset
      assign mode_set = io_wr && mine && (sel == SEL_CTL) && io_wdata[CW_FLAG];
      assign bsr = io_wr && mine && (sel == SEL_CTL) && !io_wdata[CW_FLAG];
      assign bsr_bit = io_wdata[BSR_SEL_HI:BSR_SEL_LO];

      assign a_m2 = (cfg.ga_mode == DPP_MODE2);
      assign a_hs = (cfg.ga_mode != DPP_MODE0);
      assign a_hs_in = a_hs && (a_m2 || cfg.a_in);
      assign a_hs_out = a_hs && (a_m2 || !cfg.a_in);
      assign b_hs_in = cfg.gb_m1 && cfg.b_in;
      assign b_hs_out = cfg.gb_m1 && !cfg.b_in;

      // strobe and acknowledge are active low on the line side
      assign stb_a_fall = pc_prev[PC_STB_A] && !pins[u].c[PC_STB_A];
      assign stb_a_rise = !pc_prev[PC_STB_A] && pins[u].c[PC_STB_A];
      assign ack_a_fall = pc_prev[PC_ACK_A] && !pins[u].c[PC_ACK_A];
      assign ack_a_rise = !pc_prev[PC_ACK_A] && pins[u].c[PC_ACK_A];
      assign stb_b_fall = pc_prev[PC_STB_B] && !pins[u].c[PC_STB_B];
      assign stb_b_rise = !pc_prev[PC_STB_B] && pins[u].c[PC_STB_B];

      // mode word; unit 1 decodes any mode request as mode 0
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            cfg <= dpp_decode_cw(CW_RESET, HS_OK);
         end else if (mode_set) begin
            cfg <= dpp_decode_cw(io_wdata, HS_OK);
         end
      end

      // output latches
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            lat_a <= LATCH_RESET;
            lat_b <= LATCH_RESET;
            lat_c <= LATCH_RESET;
         end else if (mode_set) begin
            lat_a <= LATCH_RESET;
            lat_b <= LATCH_RESET;
            lat_c <= LATCH_RESET;
         end else begin
            if (wr_a) begin
               lat_a <= io_wdata;
            end
            if (wr_b) begin
               lat_b <= io_wdata;
            end
            if (wr_c) begin
               lat_c <= io_wdata;
            end else if (bsr) begin
               lat_c[bsr_bit] <= io_wdata[BSR_VAL];
            end
         end
      end

      // strobed input latches
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            hold_a <= LATCH_RESET;
            hold_b <= LATCH_RESET;
         end else if (mode_set) begin
            hold_a <= LATCH_RESET;
            hold_b <= LATCH_RESET;
         end else begin
            if (a_hs_in && stb_a_fall) begin
               hold_a <= pins[u].a;
            end
            if (b_hs_in && stb_b_fall) begin
               hold_b <= pins[u].b;
            end
         end
      end

      // group A handshake status; a new event wins over a host clear
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ibf_a <= 1'b0;
            obf_a_n <= 1'b1;
            intr_a <= 1'b0;
            inte_a_in <= 1'b0;
            inte_a_out <= 1'b0;
         end else if (mode_set) begin
            ibf_a <= 1'b0;
            obf_a_n <= 1'b1;
            intr_a <= 1'b0;
            inte_a_in <= 1'b0;
            inte_a_out <= 1'b0;
         end else begin
            if (a_hs_in && stb_a_fall) begin
               ibf_a <= 1'b1;
            end else if (rd_a) begin
               ibf_a <= 1'b0;
            end
            if (a_hs_out && wr_a) begin
               obf_a_n <= 1'b0;
            end else if (a_hs_out && ack_a_fall) begin
               obf_a_n <= 1'b1;
            end
            if ((a_hs_in && inte_a_in && stb_a_rise) ||
                (a_hs_out && inte_a_out && ack_a_rise)) begin
               intr_a <= 1'b1;
            end else if ((a_hs_in && rd_a) || (a_hs_out && wr_a)) begin
               intr_a <= 1'b0;
            end
            if (bsr && (bsr_bit == 3'(PC_STB_A))) begin
               inte_a_in <= io_wdata[BSR_VAL];
            end
            if (bsr && (bsr_bit == 3'(PC_ACK_A))) begin
               inte_a_out <= io_wdata[BSR_VAL];
            end
         end
      end

      // group B handshake status
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ibf_b <= 1'b0;
            obf_b_n <= 1'b1;
            intr_b <= 1'b0;
            inte_b <= 1'b0;
         end else if (mode_set) begin
            ibf_b <= 1'b0;
            obf_b_n <= 1'b1;
            intr_b <= 1'b0;
            inte_b <= 1'b0;
         end else begin
            if (b_hs_in && stb_b_fall) begin
               ibf_b <= 1'b1;
            end else if (rd_b) begin
               ibf_b <= 1'b0;
            end
            if (b_hs_out && wr_b) begin
               obf_b_n <= 1'b0;
            end else if (b_hs_out && stb_b_fall) begin
               obf_b_n <= 1'b1;
            end
            if (inte_b && cfg.gb_m1 && stb_b_rise) begin
               intr_b <= 1'b1;
            end else if ((b_hs_in && rd_b) || (b_hs_out && wr_b)) begin
               intr_b <= 1'b0;
            end
            if (bsr && (bsr_bit == 3'(PC_STB_B))) begin
               inte_b <= io_wdata[BSR_VAL];
            end
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            pc_prev <= '1;
         end else begin
            pc_prev <= pins[u].c;
         end
      end

      // line drive: mode 0 halves first, handshake slots override them
      always_comb begin
         next_out.a = lat_a;
         next_out.b = lat_b;
         next_out.c = lat_c;
         next_oe.a = {8{!cfg.a_in}};
         next_oe.b = {8{!cfg.b_in}};
         next_oe.c = {{4{!cfg.cu_in}}, {4{!cfg.cl_in}}};
         if (a_m2) begin
            next_oe.a = {8{!pins[u].c[PC_ACK_A]}};
         end
         if (a_hs) begin
            next_out.c[PC_INTR_A] = intr_a;
            next_oe.c[PC_INTR_A] = 1'b1;
         end
         if (a_hs_in) begin
            next_oe.c[PC_STB_A] = 1'b0;
            next_out.c[PC_IBF_A] = ibf_a;
            next_oe.c[PC_IBF_A] = 1'b1;
         end
         if (a_hs_out) begin
            next_oe.c[PC_ACK_A] = 1'b0;
            next_out.c[PC_OBF_A] = obf_a_n;
            next_oe.c[PC_OBF_A] = 1'b1;
         end
         if (cfg.gb_m1) begin
            next_oe.c[PC_STB_B] = 1'b0;
            next_out.c[PC_IBF_B] = b_hs_in ? ibf_b : obf_b_n;
            next_oe.c[PC_IBF_B] = 1'b1;
            next_out.c[PC_INTR_B] = intr_b;
            next_oe.c[PC_INTR_B] = 1'b1;
         end
         // the port A buffer strap can veto or force the drive
         if (u == 0) begin
            case (buf_dir)
               DPP_BUF_OUT: next_oe.a = 8'hff;
               DPP_BUF_IN: next_oe.a = 8'h00;
               DPP_BUF_PROG: next_oe.a = next_oe.a;
               default: next_oe.a = 8'h00;
            endcase
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            out_q[u] <= '0;
            oe_q[u] <= '0;
         end else begin
            out_q[u] <= next_out;
            oe_q[u] <= next_oe;
         end
      end

      // read view: strobed ports return the held byte, inputs the pins
      always_comb begin
         case (sel)
            SEL_A: rd_val[u] = a_hs_in ? hold_a : (cfg.a_in ? pins[u].a : lat_a);
            SEL_B: rd_val[u] = b_hs_in ? hold_b : (cfg.b_in ? pins[u].b : lat_b);
            SEL_C: rd_val[u] = (next_oe.c & next_out.c) | (~next_oe.c & pins[u].c);
            default: rd_val[u] = RD_NONE;
         endcase
      end

      if (u == 0) begin : g_prog
         assign a_oe_prog = {8{!cfg.a_in || a_m2}};
      end
   end

   // host read answer one cycle after the strobe; control ports read zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         io_rdata <= RD_NONE;
         io_rd_ack <= 1'b0;
      end else begin
         io_rd_ack <= io_rd;
         if (io_rd && hit) begin
            io_rdata <= rd_val[unit];
         end else if (io_rd) begin
            io_rdata <= RD_NONE;
         end
      end
   end

   // transceiver direction follows the strap, or the programmed mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         porta_buf_transmit <= 1'b1;
      end else begin
         case (buf_dir)
            DPP_BUF_OUT: porta_buf_transmit <= 1'b1;
            DPP_BUF_IN: porta_buf_transmit <= 1'b0;
            DPP_BUF_PROG: porta_buf_transmit <= |a_oe_prog;
            default: porta_buf_transmit <= 1'b1;
         endcase
      end
   end

   assign u0_line_out = out_q[0];
   assign u0_line_oe = oe_q[0];
   assign u1_line_out = out_q[1];
   assign u1_line_oe = oe_q[1];

   // falls out of the decode: 92H gives A,B in and both C halves out

endmodule : dpp_top

`default_nettype wire

// [dpp_periph.sv]
// Purpose: peripheral side of the parallel lines for both units
// Assumes: the peripheral drives every line that the unit leaves undriven
// Notes: bench changes ext each round so stale levels never pass for data
`default_nettype none
module dpp_periph (
   input wire dpp_pkg::dpp_lines_s line_out, // unit drive values
   input wire dpp_pkg::dpp_lines_s line_oe, // unit drive enables
   input wire logic [23:0] ext, // peripheral level on quiet lines
   output var dpp_pkg::dpp_lines_s line_in // resolved pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   import dpp_pkg::*;
   // driven bits show the latch, the rest show the peripheral
   assign line_in = (line_out & line_oe) | (ext & ~line_oe);
endmodule : dpp_periph
`default_nettype wire

// [dpp_props.sv]
// Purpose: port-level checks for the dual parallel port block
// Assumes: one clock, async active-high reset
// Notes: data checks lean on unit 1, which is mode 0 only
`default_nettype none
module dpp_props (
   input wire logic sys_clk, // system clock
   input wire logic rst, // async reset
   input wire logic [7:0] io_addr, // address
   input wire logic io_wr, // write strobe
   input wire logic io_rd, // read strobe
   input wire logic [7:0] io_wdata, // write data
   input wire logic [7:0] io_rdata, // read data
   input wire logic io_rd_ack, // read answer
   input wire dpp_pkg::dpp_lines_s u0_line_in, // unit 0 pins
   input wire dpp_pkg::dpp_lines_s u0_line_out, // unit 0 drive
   input wire dpp_pkg::dpp_lines_s u0_line_oe, // unit 0 enables
   input wire dpp_pkg::dpp_lines_s u1_line_in, // unit 1 pins
   input wire dpp_pkg::dpp_lines_s u1_line_out, // unit 1 drive
   input wire dpp_pkg::dpp_lines_s u1_line_oe, // unit 1 enables
   input wire logic [1:0] buf_strap, // buffer strap
   input wire logic porta_buf_transmit // transceiver direction
);
   timeunit 1ns;
   timeprecision 1ps;
   import dpp_pkg::*;
   wire logic [2:0] bsr_sel;
   wire logic bsr_v;
   wire logic u1_cw;
   assign bsr_sel = io_wdata[3:1];
   assign bsr_v = io_wdata[0];
   assign u1_cw = io_wr && io_addr == ADDR_U1_CTL;
   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   rd_answer_a: assert property (io_rd |=> io_rd_ack)
      else $error("read not answered one cycle later");
   ack_cause_a: assert property (io_rd_ack |-> $past(io_rd))
      else $error("read answer without read");
   unmapped_zero_a: assert property (io_rd && !dpp_hit(io_addr) |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   ctl_read_zero_a: assert property (io_rd && io_addr[1:0] == 2'h3 |=> io_rdata == 8'h00)
      else $error("control port read not zero");
   mode_word_a: assert property (u1_cw && io_wdata == 8'h92 |-> ##2 u1_line_oe == 24'hff0000)
      else $error("word 92 gave wrong enables");
   mode_clear_a: assert property (u1_cw && io_wdata[7] |-> ##2 u1_line_out == 24'h0)
      else $error("mode set left latches");
   latch_hold_a: assert property ((!io_wr)[*3] |=> $stable(u1_line_out))
      else $error("output latch moved without write");
   reset_input_a: assert property ($fell(rst) |-> u1_line_oe == 24'h0 && u0_line_oe[15:0] == 16'h0)
      else $error("port driving after reset");
   strap_out_a: assert property ($fell(rst) && buf_strap == 2'h0 |-> ##2 porta_buf_transmit)
      else $error("default strap not transmit");
   bsr_bit_a: assert property (u1_cw && !io_wdata[7] |-> ##2
      (!u1_line_oe.c[$past(bsr_sel, 2)] || u1_line_out.c[$past(bsr_sel, 2)] == $past(bsr_v, 2)))
      else $error("bit set reset wrong");
   cover property (u1_cw && io_wdata == 8'h92);
   cover property (u1_cw && !io_wdata[7]);
   cover property (io_rd && !dpp_hit(io_addr));
endmodule : dpp_props
bind dpp_top dpp_props u_props (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
   .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
   .io_rd_ack(io_rd_ack), .u0_line_in(u0_line_in), .u0_line_out(u0_line_out),
   .u0_line_oe(u0_line_oe), .u1_line_in(u1_line_in), .u1_line_out(u1_line_out),
   .u1_line_oe(u1_line_oe), .buf_strap(buf_strap), .porta_buf_transmit(porta_buf_transmit));
`default_nettype wire

// [dpp_tb_top.sv]
// Purpose: self-checking bench for the dual parallel port block
// Assumes: strap at default until a closing reset, unit 1 compared with a mode 0 model
// Notes: of the unit 0 handshake modes only group B strobed input is covered, by its port effects
`default_nettype none
module dpp_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dpp_pkg::*;
   logic sys_clk, rst, io_wr, io_rd, io_rd_ack, porta_buf_transmit;
   logic [7:0] io_addr, io_wdata, io_rdata, rd_val, cw1;
   logic [1:0] buf_strap;
   dpp_lines_s u0_in, u0_out, u0_oe, u1_in, u1_out, u1_oe;
   logic [23:0] ext0, ext1, lat1;
   int err_count, cmp_count;
   dpp_top DUT (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack), .u0_line_in(u0_in),
      .u0_line_out(u0_out), .u0_line_oe(u0_oe), .u1_line_in(u1_in), .u1_line_out(u1_out),
      .u1_line_oe(u1_oe), .buf_strap(buf_strap), .porta_buf_transmit(porta_buf_transmit));
   dpp_periph u_per0 (.line_out(u0_out), .line_oe(u0_oe), .ext(ext0), .line_in(u0_in));
   dpp_periph u_per1 (.line_out(u1_out), .line_oe(u1_oe), .ext(ext1), .line_in(u1_in));
   task automatic finish_test;
      if (err_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk_rd(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_rd
   task automatic chk_ln(input string name, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_ln
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge sys_clk);
      io_wr <= 1'b0;
   endtask : io_write
   task automatic io_read(input logic [7:0] a);
      @(posedge sys_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge sys_clk);
      io_rd <= 1'b0;
      // answer comes exactly one cycle after the taking edge
      @(posedge sys_clk);
      chk_rd("read answer", 8'h01, {7'h0, io_rd_ack});
      rd_val = io_rdata;
   endtask : io_read
   function automatic logic [23:0] oe_of(input logic [7:0] cw);
      return {{4{~cw[3]}}, {4{~cw[0]}}, {8{~cw[1]}}, {8{~cw[4]}}};
   endfunction : oe_of
   task automatic u1_wr(input logic [7:0] a, input logic [7:0] d);
      io_write(a, d);
      if (a == ADDR_U1_CTL && d[7]) begin
         cw1 = d;
         lat1 = 24'h0;
      end else if (a == ADDR_U1_CTL) begin
         lat1[16 + int'(d[3:1])] = d[0];
      end else begin
         lat1[8 * int'(a - ADDR_U1_A) +: 8] = d;
      end
   endtask : u1_wr
   task automatic u1_check;
      logic [23:0] oe, exp;
      // wait first: a pin level scheduled on the caller's edge must have landed
      repeat (2) @(posedge sys_clk);
      oe = oe_of(cw1);
      exp = (lat1 & oe) | (ext1 & ~oe);
      chk_ln("u1 enables", oe, u1_oe);
      chk_ln("u1 drive", lat1, u1_out);
      for (int p = 0; p < 3; p++) begin
         io_read(ADDR_U1_A + 8'(p));
         chk_rd("u1 port read", exp[8 * p +: 8], rd_val);
      end
   endtask : u1_check
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      finish_test();
   end
   initial begin
      logic [7:0] r, cw;
      logic [7:0] bad [4];
      bad = '{ADDR_U0_CTL, ADDR_U1_CTL, 8'h10, 8'hec};
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      buf_strap = 2'h0;
      ext0 = 24'h0;
      ext1 = 24'h0;
      cw1 = CW_RESET;
      lat1 = 24'h0;
      void'($urandom(31));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      ext0 <= 24'($urandom());
      ext1 <= 24'($urandom());
      u1_check();
      chk_rd("buf transmit", 8'h01, {7'h0, porta_buf_transmit});
      for (int i = 0; i <= 16; i++) begin
         r = 8'($urandom());
         cw = (i == 16) ? 8'h92 : {1'b1, r[6:5], i[3], i[2], r[2], i[1], i[0]};
         u1_wr(ADDR_U1_CTL, cw);
         u1_wr(ADDR_U1_A, r);
         u1_wr(ADDR_U1_C, ~r);
         u1_wr(ADDR_U1_CTL, cw);
         u1_check();
         u1_wr(ADDR_U1_B, 8'($urandom()));
         u1_wr(ADDR_U1_C, 8'($urandom()));
         u1_wr(ADDR_U1_CTL, {4'h0, r[3:0]});
         ext1 <= 24'($urandom());
         u1_check();
      end
      io_write(ADDR_U0_CTL, 8'h92);
      io_write(ADDR_U0_C, r);
      io_write(ADDR_U0_CTL, {7'h02, ~r[2]});
      repeat (2) @(posedge sys_clk);
      chk_rd("u0 port c drive", r ^ 8'h04, u0_out.c);
      chk_ln("u0 enables", 24'hff00ff, u0_oe);
      io_read(ADDR_U0_C);
      chk_rd("u0 port c read", r ^ 8'h04, rd_val);
      io_read(ADDR_U0_B);
      chk_rd("u0 port b read", ext0[15:8], rd_val);
      foreach (bad[k]) begin
         io_read(bad[k]);
         chk_rd("unmapped or control read", 8'h00, rd_val);
      end
      // group B strobed input; interrupt enable goes last so the release of PC2 adds no event
      ext0 <= 24'h045a00;
      io_write(ADDR_U0_CTL, 8'h86);
      io_write(ADDR_U0_CTL, 8'h0f);
      io_write(ADDR_U0_CTL, 8'h05);
      repeat (2) @(posedge sys_clk);
      chk_ln("u0 handshake enables", 24'hfb00ff, u0_oe);
      ext0 <= 24'h005a00;
      repeat (4) @(posedge sys_clk);
      ext0 <= 24'h045a00;
      repeat (5) @(posedge sys_clk);
      chk_rd("u0 port c status", 8'h83, u0_out.c & 8'h83);
      io_read(ADDR_U0_B);
      chk_rd("u0 strobed read", 8'h5a, rd_val);
      repeat (2) @(posedge sys_clk);
      chk_rd("u0 status cleared", 8'h80, u0_out.c & 8'h83);
      // a stray write outside the map must leave unit 1 alone
      io_write(8'h20, 8'hff);
      u1_check();
      // closing reset with the input strap: transceiver and port A turn inward
      buf_strap <= 2'h1;
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk_rd("buf transmit", 8'h00, {7'h0, porta_buf_transmit});
      chk_ln("u0 enables", 24'h0, u0_oe);
      finish_test();
   end
endmodule : dpp_tb_top
`default_nettype wire
